// [hdl/opdec_pkg.sv]
// Package: opcode decoder encodings, lengths, timings and field positions
//
// Summary of operation
// [RULE1] AND into accumulator: 5*,55,56/57,54; one cycle
// [RULE2] AND direct: 52 two bytes; 53 three bytes/two
// [RULE3] OR into accumulator: 4*,45,46/47,44; one cycle
// [RULE4] OR direct: 42 two bytes; 43 three/two cycles
// [RULE5] XOR into accumulator: 6*,65,66/67,64; one cycle
// [RULE6] XOR direct: 62 two bytes; 63 three/two cycles
// [RULE7] Rotate left 23, through carry 33
// [RULE8] Rotate right 03, through carry 13
// [RULE9] C4 swaps accumulator nibbles, one byte
// [RULE10] Load accumulator: E*,E5,E6/E7,74 one cycle
// [RULE11] Store accumulator: F*,F5,F6/F7 one cycle
// [RULE12] A* register from direct two cycles; 7* one
// [RULE13] Direct write: 8*,85,86/87,75 two cycles
// [RULE14] Indirect write: A6/A7 two cycles; 76/77 one
// [RULE15] 90 loads sixteen-bit data pointer, three bytes
// [RULE16] Code read: 93 pointer-based, 83 counter-based
// [RULE17] External read: E2/E3 8-bit, E0 pointer
// [RULE18] External write: F2/F3 8-bit, F0 pointer
// [RULE19] C0 push, D0 pop; two bytes, two cycles
// [RULE20] Exchange accumulator: C*,C5,C6/C7 one cycle
// [RULE21] D6/D7 exchange low digits only
// [RULE22] Software avoids direct move from accumulator location
// [RULE23] Asterisk group means low digit 8 to F
// [RULE24] Indirect address from bank R0 or R1
// [RULE25] Immediates from stream; pointer uses bytes 2,3
// [RULE26] Low three bits pick register; bit0 R0/R1
package opdec_pkg;

   // ==========================================================
   // Operation classes
   typedef enum logic [4:0] {
      NO_OP, BITWISE_AND_OP, BITWISE_OR_OP, BITWISE_XOR_OP,
      CLEAR_ACCUMULATOR_OP, INVERT_ACCUMULATOR_OP,
      ROTATE_LEFT_OP, ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_OP,
      ROTATE_RIGHT_CARRY_OP, SWAP_NIBBLE_OP, MOVE_OP,
      LOAD_POINTER_OP, CODE_TABLE_READ_OP, EXTERNAL_DATA_MOVE_OP,
      PUSH_OP, POP_OP, EXCHANGE_OP, EXCHANGE_LOW_DIGIT_OP
   } op_type;

   // ==========================================================
   // Operand locations
   typedef enum logic [3:0] {
      LOC_NONE, LOC_ACC, LOC_REG, LOC_DIRECT, LOC_INDIRECT,
      LOC_IMM, LOC_POINTER, LOC_CODE_PTR, LOC_CODE_PC,
      LOC_EXT_SHORT, LOC_EXT_POINTER, LOC_STACK, LOC_DIRECT2
   } loc_type;

   // ==========================================================
   // Field positions and group encodings
   localparam int         HI_MSB          = 7;
   localparam int         HI_LSB          = 4;
   localparam int         LO_MSB          = 3;
   localparam int         LO_LSB          = 0;
   localparam logic [3:0] GRP_OR          = 4'h4;
   localparam logic [3:0] GRP_AND         = 4'h5;
   localparam logic [3:0] GRP_XOR         = 4'h6;
   localparam logic [3:0] GRP_MOV_IMM     = 4'h7;
   localparam logic [3:0] GRP_MOV_DIR     = 4'h8;
   localparam logic [3:0] GRP_MOV_REGDIR  = 4'ha;
   localparam logic [3:0] GRP_EXCH        = 4'hc;
   localparam logic [3:0] GRP_LOWDIG_POP  = 4'hd;
   localparam logic [3:0] GRP_LOAD_ACC    = 4'he;
   localparam logic [3:0] GRP_STORE_ACC   = 4'hf;
   localparam logic [3:0] LO_DIR_ACC      = 4'h2;
   localparam logic [3:0] LO_DIR_IMM      = 4'h3;
   localparam logic [3:0] LO_IMM          = 4'h4;
   localparam logic [3:0] LO_DIRECT       = 4'h5;
   localparam logic [3:0] LO_IND0         = 4'h6;
   localparam logic [3:0] LO_IND1         = 4'h7;

   // ==========================================================
   // Single opcodes
   localparam logic [7:0] OPC_ROT_R       = 8'h03;
   localparam logic [7:0] OPC_ROT_RC      = 8'h13;
   localparam logic [7:0] OPC_ROT_L       = 8'h23;
   localparam logic [7:0] OPC_ROT_LC      = 8'h33;
   localparam logic [7:0] OPC_MOV_A_IMM   = 8'h74;
   localparam logic [7:0] OPC_MOV_D_IMM   = 8'h75;
   localparam logic [7:0] OPC_CODE_PC     = 8'h83;
   localparam logic [7:0] OPC_MOV_D_D     = 8'h85;
   localparam logic [7:0] OPC_LOAD_PTR    = 8'h90;
   localparam logic [7:0] OPC_CODE_PTR    = 8'h93;
   localparam logic [7:0] OPC_PUSH        = 8'hc0;
   localparam logic [7:0] OPC_EXCH_DIR    = 8'hc5;
   localparam logic [7:0] OPC_A_FROM_DIR  = 8'he5;
   localparam logic [7:0] OPC_A_TO_DIR    = 8'hf5;
   localparam logic [7:0] OPC_SWAP        = 8'hc4;
   localparam logic [7:0] OPC_POP         = 8'hd0;
   localparam logic [7:0] OPC_XRD_PTR     = 8'he0;
   localparam logic [7:0] OPC_XRD_R0      = 8'he2;
   localparam logic [7:0] OPC_XRD_R1      = 8'he3;
   localparam logic [7:0] OPC_CLEAR_A     = 8'he4;
   localparam logic [7:0] OPC_XWR_PTR     = 8'hf0;
   localparam logic [7:0] OPC_XWR_R0      = 8'hf2;
   localparam logic [7:0] OPC_XWR_R1      = 8'hf3;
   localparam logic [7:0] OPC_INVERT_A    = 8'hf4;
   localparam logic [7:0] ACC_SFR_ADDR    = 8'he0;

   // ==========================================================
   // Lengths, cycle counts and timing
   localparam logic [1:0] LEN_1           = 2'h1;
   localparam logic [1:0] LEN_2           = 2'h2;
   localparam logic [1:0] LEN_3           = 2'h3;
   localparam logic [2:0] CYC_1           = 3'h1;
   localparam logic [2:0] CYC_2           = 3'h2;
   localparam int         CLK_PER_MCYC    = 12;
   localparam logic [3:0] MCYC_LAST       = 4'(CLK_PER_MCYC - 1);

endpackage

// [hdl/opdec_table.sv]
// Combinational opcode table: class, operands, length and timing
`timescale 1ns/1ps
module opdec_table
   import opdec_pkg::*;
(
   input  wire logic [7:0] opcode_i,
   output op_type          op_o,
   output loc_type         src_o,
   output loc_type         dst_o,
   output logic [1:0]      len_o,
   output logic [2:0]      cyc_o,
   output logic            valid_o
);

   logic [3:0] hi;
   logic [3:0] lo;
   assign hi = opcode_i[HI_MSB:HI_LSB];
   assign lo = opcode_i[LO_MSB:LO_LSB];

   // Low digit 8..F marks a register group
   function automatic logic is_reg_grp(input logic [3:0] l);
      return l[3];
   endfunction

   function automatic logic is_ind(input logic [3:0] l);
      return (l == LO_IND0) || (l == LO_IND1);
   endfunction

   always_comb begin
      op_o    = NO_OP;
      src_o   = LOC_NONE;
      dst_o   = LOC_NONE;
      len_o   = LEN_1;
      cyc_o   = CYC_1;
      valid_o = 1'b1;
      // ==========================================================
      // Logic groups share one layout
      if (hi == GRP_AND || hi == GRP_OR || hi == GRP_XOR) begin
         op_o  = (hi == GRP_AND) ? BITWISE_AND_OP :
                 (hi == GRP_OR)  ? BITWISE_OR_OP : BITWISE_XOR_OP;
         dst_o = LOC_ACC;
         if (is_reg_grp(lo)) begin
            src_o = LOC_REG; // RULE1 RULE3 RULE5 RULE23
         end else if (lo == LO_DIRECT) begin
            src_o = LOC_DIRECT;
            len_o = LEN_2;
         end else if (is_ind(lo)) begin
            src_o = LOC_INDIRECT; // RULE24
         end else if (lo == LO_IMM) begin
            src_o = LOC_IMM; // RULE25
            len_o = LEN_2;
         end else if (lo == LO_DIR_ACC) begin
            src_o = LOC_ACC; // RULE2 RULE4 RULE6
            dst_o = LOC_DIRECT;
            len_o = LEN_2;
         end else if (lo == LO_DIR_IMM) begin
            src_o = LOC_IMM; // RULE2 RULE4 RULE6
            dst_o = LOC_DIRECT;
            len_o = LEN_3;
            cyc_o = CYC_2;
         end else begin
            op_o    = NO_OP;
            dst_o   = LOC_NONE;
            valid_o = 1'b0;
         end
      end else if (is_reg_grp(lo) && hi == GRP_LOAD_ACC) begin
         op_o = MOVE_OP; src_o = LOC_REG; dst_o = LOC_ACC; // RULE10
      end else if (is_reg_grp(lo) && hi == GRP_STORE_ACC) begin
         op_o = MOVE_OP; src_o = LOC_ACC; dst_o = LOC_REG; // RULE11
      end else if (is_reg_grp(lo) && hi == GRP_MOV_REGDIR) begin
         op_o = MOVE_OP; src_o = LOC_DIRECT; dst_o = LOC_REG; // RULE12
         len_o = LEN_2; cyc_o = CYC_2;
      end else if (is_reg_grp(lo) && hi == GRP_MOV_IMM) begin
         op_o = MOVE_OP; src_o = LOC_IMM; dst_o = LOC_REG; // RULE12
         len_o = LEN_2;
      end else if (is_reg_grp(lo) && hi == GRP_MOV_DIR) begin
         op_o = MOVE_OP; src_o = LOC_REG; dst_o = LOC_DIRECT; // RULE13
         len_o = LEN_2; cyc_o = CYC_2;
      end else if (is_reg_grp(lo) && hi == GRP_EXCH) begin
         op_o = EXCHANGE_OP; src_o = LOC_REG; dst_o = LOC_ACC; // RULE20
      end else if (is_ind(lo) && hi == GRP_LOAD_ACC) begin
         op_o = MOVE_OP; src_o = LOC_INDIRECT; dst_o = LOC_ACC; // RULE10
      end else if (is_ind(lo) && hi == GRP_STORE_ACC) begin
         op_o = MOVE_OP; src_o = LOC_ACC; dst_o = LOC_INDIRECT; // RULE11
      end else if (is_ind(lo) && hi == GRP_MOV_REGDIR) begin
         op_o = MOVE_OP; src_o = LOC_DIRECT; dst_o = LOC_INDIRECT; // RULE14
         len_o = LEN_2; cyc_o = CYC_2;
      end else if (is_ind(lo) && hi == GRP_MOV_IMM) begin
         op_o = MOVE_OP; src_o = LOC_IMM; dst_o = LOC_INDIRECT; // RULE14
         len_o = LEN_2;
      end else if (is_ind(lo) && hi == GRP_MOV_DIR) begin
         op_o = MOVE_OP; src_o = LOC_INDIRECT; dst_o = LOC_DIRECT; // RULE13
         len_o = LEN_2; cyc_o = CYC_2;
      end else if (is_ind(lo) && hi == GRP_EXCH) begin
         op_o = EXCHANGE_OP; src_o = LOC_INDIRECT; dst_o = LOC_ACC; // RULE20
      end else if (is_ind(lo) && hi == GRP_LOWDIG_POP) begin
         op_o = EXCHANGE_LOW_DIGIT_OP; // RULE21
         src_o = LOC_INDIRECT; dst_o = LOC_ACC;
      end else begin
         unique case (opcode_i)
            OPC_ROT_L:  op_o = ROTATE_LEFT_OP; // RULE7
            OPC_ROT_LC: op_o = ROTATE_LEFT_CARRY_OP; // RULE7
            OPC_ROT_R:  op_o = ROTATE_RIGHT_OP; // RULE8
            OPC_ROT_RC: op_o = ROTATE_RIGHT_CARRY_OP; // RULE8
            OPC_SWAP: op_o = SWAP_NIBBLE_OP; // RULE9
            OPC_CLEAR_A: op_o = CLEAR_ACCUMULATOR_OP;
            OPC_INVERT_A: op_o = INVERT_ACCUMULATOR_OP;
            OPC_A_FROM_DIR: begin
               op_o = MOVE_OP; src_o = LOC_DIRECT; // RULE10
               len_o = LEN_2;
            end
            OPC_MOV_A_IMM: begin
               op_o = MOVE_OP; src_o = LOC_IMM; // RULE10
               len_o = LEN_2;
            end
            OPC_A_TO_DIR: begin
               op_o = MOVE_OP; src_o = LOC_ACC; dst_o = LOC_DIRECT; // RULE11
               len_o = LEN_2;
            end
            OPC_MOV_D_D: begin
               op_o = MOVE_OP; src_o = LOC_DIRECT2; // RULE13
               dst_o = LOC_DIRECT; len_o = LEN_3; cyc_o = CYC_2;
            end
            OPC_MOV_D_IMM: begin
               op_o = MOVE_OP; src_o = LOC_IMM; dst_o = LOC_DIRECT; // RULE13
               len_o = LEN_3; cyc_o = CYC_2;
            end
            OPC_LOAD_PTR: begin
               op_o = LOAD_POINTER_OP; src_o = LOC_IMM; // RULE15
               dst_o = LOC_POINTER; len_o = LEN_3; cyc_o = CYC_2;
            end
            OPC_CODE_PTR: begin
               op_o = CODE_TABLE_READ_OP; src_o = LOC_CODE_PTR; // RULE16
               cyc_o = CYC_2;
            end
            OPC_CODE_PC: begin
               op_o = CODE_TABLE_READ_OP; src_o = LOC_CODE_PC; // RULE16
               cyc_o = CYC_2;
            end
            OPC_XRD_R0, OPC_XRD_R1: begin
               op_o = EXTERNAL_DATA_MOVE_OP; src_o = LOC_EXT_SHORT; // RULE17
               cyc_o = CYC_2;
            end
            OPC_XRD_PTR: begin
               op_o = EXTERNAL_DATA_MOVE_OP; src_o = LOC_EXT_POINTER; // RULE17
               cyc_o = CYC_2;
            end
            OPC_XWR_R0, OPC_XWR_R1: begin
               op_o = EXTERNAL_DATA_MOVE_OP; src_o = LOC_ACC; // RULE18
               dst_o = LOC_EXT_SHORT; cyc_o = CYC_2;
            end
            OPC_XWR_PTR: begin
               op_o = EXTERNAL_DATA_MOVE_OP; src_o = LOC_ACC; // RULE18
               dst_o = LOC_EXT_POINTER; cyc_o = CYC_2;
            end
            OPC_PUSH: begin
               op_o = PUSH_OP; src_o = LOC_DIRECT; dst_o = LOC_STACK; // RULE19
               len_o = LEN_2; cyc_o = CYC_2;
            end
            OPC_POP: begin
               op_o = POP_OP; src_o = LOC_STACK; dst_o = LOC_DIRECT; // RULE19
               len_o = LEN_2; cyc_o = CYC_2;
            end
            OPC_EXCH_DIR: begin
               op_o = EXCHANGE_OP; src_o = LOC_DIRECT; // RULE20
               len_o = LEN_2;
            end
            default: valid_o = 1'b0;
         endcase
         if (op_o inside {ROTATE_LEFT_OP, ROTATE_LEFT_CARRY_OP,
                          ROTATE_RIGHT_OP, ROTATE_RIGHT_CARRY_OP,
                          SWAP_NIBBLE_OP, CLEAR_ACCUMULATOR_OP,
                          INVERT_ACCUMULATOR_OP}) begin
            src_o = LOC_ACC;
            dst_o = LOC_ACC;
         end else if (op_o == MOVE_OP && dst_o == LOC_NONE) begin
            dst_o = LOC_ACC;
         end else if (op_o == EXCHANGE_OP) begin
            dst_o = LOC_ACC;
         end else if (op_o == CODE_TABLE_READ_OP ||
                      (op_o == EXTERNAL_DATA_MOVE_OP &&
                       src_o != LOC_ACC)) begin
            dst_o = LOC_ACC;
         end
      end
   end

endmodule

// [hdl/opdec_core.sv]
// Opcode decoder with registered results and machine-cycle timing
`timescale 1ns/1ps
module opdec_core
   import opdec_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       start_i,
   input  wire logic [7:0] opcode_i,
   input  wire logic [7:0] byte2_i,
   input  wire logic [7:0] byte3_i,
   input  wire logic [7:0] bank_i,
   output op_type          op_o,
   output loc_type         src_o,
   output loc_type         dst_o,
   output logic [1:0]      len_o,
   output logic [2:0]      cyc_o,
   output logic [2:0]      reg_sel_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      imm_o,
   output logic [15:0]     pointer_imm_o,
   output logic            illegal_o,
   output logic            acc_self_move_o,
   output logic            busy_o,
   output logic            done_o
);

   // ==========================================================
   // Table lookup
   op_type     t_op;
   loc_type    t_src;
   loc_type    t_dst;
   logic [1:0] t_len;
   logic [2:0] t_cyc;
   logic       t_valid;

   opdec_table u_table (
      .opcode_i (opcode_i),
      .op_o     (t_op),
      .src_o    (t_src),
      .dst_o    (t_dst),
      .len_o    (t_len),
      .cyc_o    (t_cyc),
      .valid_o  (t_valid)
   );

   typedef enum logic [0:0] {IDLE, EXEC} state_type;
   state_type  state;
   logic [3:0] clk_cnt;
   logic [2:0] mcyc_left;
   logic       accept;

   assign accept = start_i && (state == IDLE);

   // Register select: three bits for groups, bit0 for paired indirect
   function automatic logic [2:0] pick_reg(input logic [7:0] opc);
      return opc[3] ? opc[2:0] : {2'b00, opc[0]};
   endfunction

   // ==========================================================
   // Decode capture
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         op_o            <= NO_OP;
         src_o           <= LOC_NONE;
         dst_o           <= LOC_NONE;
         len_o           <= LEN_1;
         cyc_o           <= CYC_1;
         reg_sel_o       <= 3'h0;
         reg_addr_o      <= 8'h00;
         imm_o           <= 8'h00;
         pointer_imm_o   <= 16'h0000;
         illegal_o       <= 1'b0;
         acc_self_move_o <= 1'b0;
      end else if (accept) begin
         op_o          <= t_op;
         src_o         <= t_src;
         dst_o         <= t_dst;
         len_o         <= t_len;
         cyc_o         <= t_cyc;
         illegal_o     <= !t_valid;
         reg_sel_o     <= pick_reg(opcode_i); // RULE26
         // Bank base plus register number
         reg_addr_o    <= 8'(bank_i + {5'h00, pick_reg(opcode_i)}); // RULE24
         // Three-byte immediates sit in the last byte
         imm_o         <= (t_len == LEN_3) ? byte3_i : byte2_i; // RULE25
         pointer_imm_o <= {byte2_i, byte3_i}; // RULE25
         // Flagged only; the move itself is not executed specially
         acc_self_move_o <= (opcode_i == OPC_A_FROM_DIR) &&
                            (byte2_i == ACC_SFR_ADDR); // RULE22
      end
   end

   // ==========================================================
   // Machine-cycle timing
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state     <= IDLE;
         clk_cnt   <= 4'h0;
         mcyc_left <= 3'h0;
         busy_o    <= 1'b0;
         done_o    <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            IDLE: begin
               if (accept) begin
                  state     <= EXEC;
                  clk_cnt   <= 4'h0;
                  mcyc_left <= t_cyc;
                  busy_o    <= 1'b1;
               end
            end
            EXEC: begin
               if (clk_cnt == MCYC_LAST) begin
                  clk_cnt <= 4'h0;
                  if (mcyc_left == CYC_1) begin
                     state  <= IDLE;
                     busy_o <= 1'b0;
                     done_o <= 1'b1;
                  end else begin
                     mcyc_left <= mcyc_left - 3'h1;
                  end
               end else begin
                  clk_cnt <= clk_cnt + 4'h1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   chk_and_direct_imm: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'h53 |=>
      len_o == LEN_3 && cyc_o == CYC_2 && dst_o == LOC_DIRECT)
      else $error("and direct immediate misdecoded"); // RULE2
   chk_and_reg_group: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i[7:3] == 5'b01011 |=>
      op_o == BITWISE_AND_OP && src_o == LOC_REG && len_o == LEN_1)
      else $error("and register group misdecoded"); // RULE1
   chk_or_imm_len: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'h44 |=>
      op_o == BITWISE_OR_OP && len_o == LEN_2 && cyc_o == CYC_1)
      else $error("or immediate misdecoded"); // RULE3
   chk_xor_direct_acc: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'h62 |=>
      op_o == BITWISE_XOR_OP && src_o == LOC_ACC && len_o == LEN_2)
      else $error("xor direct accumulator misdecoded"); // RULE6
   chk_load_pointer: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'h90 |=>
      pointer_imm_o == {$past(byte2_i), $past(byte3_i)} && len_o == LEN_3)
      else $error("pointer load misdecoded"); // RULE15
   chk_swap_nibble: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'hc4 |=>
      op_o == SWAP_NIBBLE_OP && cyc_o == CYC_1)
      else $error("swap misdecoded"); // RULE9
   chk_indirect_reg: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && opcode_i == 8'he7 |=>
      reg_sel_o == 3'h1 && src_o == LOC_INDIRECT)
      else $error("indirect register select wrong"); // RULE24
   sequence two_mcyc_run;
      busy_o [*8] ##1 busy_o [*8] ##1 busy_o [*7];
   endsequence
   chk_two_cycle_time: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && t_cyc == CYC_2 |=>
      two_mcyc_run ##1 busy_o ##1 !busy_o && done_o)
      else $error("two machine cycle timing wrong"); // RULE19
   chk_one_cycle_time: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i) accept && t_cyc == CYC_1 |=>
      busy_o [*8] ##1 busy_o [*4] ##1 done_o)
      else $error("one machine cycle timing wrong"); // RULE1

endmodule

// [verif/tb.sv]
// Testbench for the opcode decoder core
`timescale 1ns/1ps
module tb
   import opdec_pkg::*;
;
   logic        core_clk_i;
   logic        resetn_i;
   logic        start_i;
   logic [7:0]  opcode_i;
   logic [7:0]  byte2_i;
   logic [7:0]  byte3_i;
   logic [7:0]  bank_i;
   op_type      op_o;
   loc_type     src_o;
   loc_type     dst_o;
   logic [1:0]  len_o;
   logic [2:0]  cyc_o;
   logic [2:0]  reg_sel_o;
   logic [7:0]  reg_addr_o;
   logic [7:0]  imm_o;
   logic [15:0] pointer_imm_o;
   logic        illegal_o;
   logic        acc_self_move_o;
   logic        busy_o;
   logic        done_o;
   int          err_total;
   int          samples_checked;
   int          wait_n;

   opdec_core u_opdec_core (
      .core_clk_i      (core_clk_i),
      .resetn_i        (resetn_i),
      .start_i         (start_i),
      .opcode_i        (opcode_i),
      .byte2_i         (byte2_i),
      .byte3_i         (byte3_i),
      .bank_i          (bank_i),
      .op_o            (op_o),
      .src_o           (src_o),
      .dst_o           (dst_o),
      .len_o           (len_o),
      .cyc_o           (cyc_o),
      .reg_sel_o       (reg_sel_o),
      .reg_addr_o      (reg_addr_o),
      .imm_o           (imm_o),
      .pointer_imm_o   (pointer_imm_o),
      .illegal_o       (illegal_o),
      .acc_self_move_o (acc_self_move_o),
      .busy_o          (busy_o),
      .done_o          (done_o)
   );

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Counts edges until done_o; running past the limit is a mismatch
   task automatic wait_done();
      while (done_o !== 1'b1 && wait_n < 40) begin
         @(posedge core_clk_i);
         #1;
         wait_n++;
      end
      if (done_o !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED done expected 1 seen %b", done_o);
      end
   endtask

   // Entered just after an edge; returns in the cycle done_o is high
   task automatic issue(input logic [7:0] opc, input logic [7:0] b2,
                        input logic [7:0] b3);
      opcode_i = opc;
      byte2_i = b2;
      byte3_i = b3;
      start_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      start_i = 1'b0;
      wait_n = 0;
      wait_done();
   endtask

   task automatic dec(input logic [7:0] opc, input op_type op,
                      input logic [1:0] len, input logic [2:0] cyc);
      issue(opc, 8'h21, 8'h43);
      chk("op", 16'(op), 16'(op_o));
      chk("len", 16'(len), 16'(len_o));
      chk("cyc", 16'(cyc), 16'(cyc_o));
      chk("cycles to done", 16'(CLK_PER_MCYC * cyc), 16'(wait_n));
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk("reset op", 16'(NO_OP), 16'(op_o));
      chk("reset len", 16'h0001, 16'(len_o));
      chk("reset cyc", 16'h0001, 16'(cyc_o));
      chk("reset busy", 16'h0000, 16'(busy_o));
      $display("test reset finished");
   endtask

   task automatic t_table();
      dec(8'h5f, BITWISE_AND_OP, 2'h1, 3'h1);
      dec(8'h55, BITWISE_AND_OP, 2'h2, 3'h1);
      dec(8'h57, BITWISE_AND_OP, 2'h1, 3'h1);
      dec(8'h54, BITWISE_AND_OP, 2'h2, 3'h1);
      dec(8'h52, BITWISE_AND_OP, 2'h2, 3'h1);
      dec(8'h53, BITWISE_AND_OP, 2'h3, 3'h2);
      dec(8'h48, BITWISE_OR_OP, 2'h1, 3'h1);
      dec(8'h45, BITWISE_OR_OP, 2'h2, 3'h1);
      dec(8'h46, BITWISE_OR_OP, 2'h1, 3'h1);
      dec(8'h44, BITWISE_OR_OP, 2'h2, 3'h1);
      dec(8'h42, BITWISE_OR_OP, 2'h2, 3'h1);
      dec(8'h43, BITWISE_OR_OP, 2'h3, 3'h2);
      dec(8'h6a, BITWISE_XOR_OP, 2'h1, 3'h1);
      dec(8'h65, BITWISE_XOR_OP, 2'h2, 3'h1);
      dec(8'h67, BITWISE_XOR_OP, 2'h1, 3'h1);
      dec(8'h64, BITWISE_XOR_OP, 2'h2, 3'h1);
      dec(8'h62, BITWISE_XOR_OP, 2'h2, 3'h1);
      dec(8'h63, BITWISE_XOR_OP, 2'h3, 3'h2);
      dec(8'h23, ROTATE_LEFT_OP, 2'h1, 3'h1);
      dec(8'h33, ROTATE_LEFT_CARRY_OP, 2'h1, 3'h1);
      dec(8'h03, ROTATE_RIGHT_OP, 2'h1, 3'h1);
      dec(8'h13, ROTATE_RIGHT_CARRY_OP, 2'h1, 3'h1);
      dec(8'hc4, SWAP_NIBBLE_OP, 2'h1, 3'h1);
      dec(8'he8, MOVE_OP, 2'h1, 3'h1);
      dec(8'he5, MOVE_OP, 2'h2, 3'h1);
      dec(8'h74, MOVE_OP, 2'h2, 3'h1);
      dec(8'hff, MOVE_OP, 2'h1, 3'h1);
      dec(8'hf5, MOVE_OP, 2'h2, 3'h1);
      dec(8'hf6, MOVE_OP, 2'h1, 3'h1);
      dec(8'ha9, MOVE_OP, 2'h2, 3'h2);
      dec(8'h7b, MOVE_OP, 2'h2, 3'h1);
      dec(8'h8c, MOVE_OP, 2'h2, 3'h2);
      dec(8'h85, MOVE_OP, 2'h3, 3'h2);
      dec(8'h86, MOVE_OP, 2'h2, 3'h2);
      dec(8'h75, MOVE_OP, 2'h3, 3'h2);
      dec(8'ha7, MOVE_OP, 2'h2, 3'h2);
      dec(8'h76, MOVE_OP, 2'h2, 3'h1);
      dec(8'h90, LOAD_POINTER_OP, 2'h3, 3'h2);
      dec(8'h93, CODE_TABLE_READ_OP, 2'h1, 3'h2);
      dec(8'h83, CODE_TABLE_READ_OP, 2'h1, 3'h2);
      dec(8'he3, EXTERNAL_DATA_MOVE_OP, 2'h1, 3'h2);
      dec(8'he0, EXTERNAL_DATA_MOVE_OP, 2'h1, 3'h2);
      dec(8'hf2, EXTERNAL_DATA_MOVE_OP, 2'h1, 3'h2);
      dec(8'hf0, EXTERNAL_DATA_MOVE_OP, 2'h1, 3'h2);
      dec(8'hc0, PUSH_OP, 2'h2, 3'h2);
      dec(8'hd0, POP_OP, 2'h2, 3'h2);
      dec(8'hcd, EXCHANGE_OP, 2'h1, 3'h1);
      dec(8'hc5, EXCHANGE_OP, 2'h2, 3'h1);
      dec(8'hc7, EXCHANGE_OP, 2'h1, 3'h1);
      dec(8'hd6, EXCHANGE_LOW_DIGIT_OP, 2'h1, 3'h1);
      dec(8'he4, CLEAR_ACCUMULATOR_OP, 2'h1, 3'h1);
      dec(8'hf4, INVERT_ACCUMULATOR_OP, 2'h1, 3'h1);
      $display("test table finished");
   endtask

   task automatic t_fields();
      bank_i = 8'h18;
      issue(8'h7d, 8'h5a, 8'h00);
      chk("reg sel", 16'h0005, 16'(reg_sel_o));
      chk("reg addr", 16'h001d, 16'(reg_addr_o));
      chk("imm", 16'h005a, 16'(imm_o));
      issue(8'h87, 8'h30, 8'h00);
      chk("ind sel", 16'h0001, 16'(reg_sel_o));
      chk("ind addr", 16'h0019, 16'(reg_addr_o));
      chk("ind src", 16'(LOC_INDIRECT), 16'(src_o));
      issue(8'h75, 8'h30, 8'h9c);
      chk("imm3", 16'h009c, 16'(imm_o));
      issue(8'h90, 8'hbe, 8'hef);
      chk("pointer", 16'hbeef, pointer_imm_o);
      chk("legal", 16'h0000, 16'(illegal_o));
      issue(8'he5, 8'he0, 8'h00);
      chk("self move", 16'h0001, 16'(acc_self_move_o));
      issue(8'he5, 8'he1, 8'h00);
      chk("other move", 16'h0000, 16'(acc_self_move_o));
      bank_i = 8'h00;
      issue(8'he6, 8'h00, 8'h00);
      chk("bank0 addr", 16'h0000, 16'(reg_addr_o));
      chk("dst acc", 16'(LOC_ACC), 16'(dst_o));
      issue(8'ha5, 8'h00, 8'h00);
      chk("illegal", 16'h0001, 16'(illegal_o));
      $display("test fields finished");
   endtask

   // A request held during execution must be ignored
   task automatic t_refuse();
      opcode_i = 8'h53;
      start_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      // Second opcode offered only while busy, so never taken
      opcode_i = 8'h23;
      repeat (10) @(posedge core_clk_i);
      #1;
      start_i = 1'b0;
      wait_n = 10;
      wait_done();
      chk("refused op", 16'(BITWISE_AND_OP), 16'(op_o));
      chk("refused span", 16'(CLK_PER_MCYC * 2), 16'(wait_n));
      $display("test refuse finished");
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   initial begin
      #50000;
      err_total++;
      final_report();
   end

   initial begin
      err_total = 0;
      samples_checked = 0;
      resetn_i = 1'b0;
      start_i = 1'b0;
      opcode_i = 8'h00;
      byte2_i = 8'h00;
      byte3_i = 8'h00;
      bank_i = 8'h08;
      repeat (10) @(posedge core_clk_i);
      #1;
      resetn_i = 1'b1;
      t_reset();
      t_table();
      t_fields();
      t_refuse();
      final_report();
   end
endmodule
